// ==== hw/psi_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts of the status/irq unit
// Assumes: 5-bit management register addresses, 16-bit register data
// Notes: definitions only
`ifndef PSI_CFG_SVH
`define PSI_CFG_SVH

// register offsets
`define PSI_OFS_SUMMARY 5'h10
`define PSI_OFS_CONTROL 5'h11
`define PSI_OFS_STATUS 5'h12
`define PSI_OFS_FC_CNT 5'h14
`define PSI_OFS_RXE_CNT 5'h15

// summary field positions
`define PSI_SUM_LINK 0
`define PSI_SUM_SPEED10 1
`define PSI_SUM_DUPLEX 2
`define PSI_SUM_LOOPBACK 3
`define PSI_SUM_AN_DONE 4
`define PSI_SUM_JABBER 5
`define PSI_SUM_IRQ_PEND 7

// control field positions
`define PSI_CTL_OUT_SEL 0
`define PSI_CTL_GLOBAL_EN 1
`define PSI_CTL_TEST_FORCE 2
`define PSI_CTL_WIDTH 3

// event positions inside the 8-bit event vector, status bit = position + 8
`define PSI_EV_RXE_HALF 0
`define PSI_EV_FC_HALF 1
`define PSI_EV_AN_DONE 2
`define PSI_EV_DUPLEX 3
`define PSI_EV_SPEED 4
`define PSI_EV_LINK 5
`define PSI_EV_ENERGY 6
`define PSI_EV_LINK_QUAL 7
`define PSI_STATUS_LSB 8

// reset values
`define PSI_RST_CONTROL 3'h0
`define PSI_RST_EVENTS 8'h00
`define PSI_RST_WORD 16'h0000

// counter figures
`define PSI_CNT_MAX 8'hFF
`define PSI_CNT_ONE 8'h01
`define PSI_CNT_ZERO 8'h00

`endif

// ==== hw/psi_pkg.sv ====
// Purpose: shared types of the status/irq unit
// Assumes: psi_cfg.svh supplies the numbers
// Notes: types only
package psi_pkg;
  typedef logic [15:0] psi_word_t;
  typedef logic [4:0] psi_addr_t;
  typedef logic [7:0] psi_evt_t;
  typedef logic [7:0] psi_cnt_t;
endpackage

// ==== hw/psi_sat_cnt.sv ====
// Purpose: saturating event counter with clear-on-read and half-full event
// Assumes: inc and clr come from logic on sys_clk
// Notes: half_evt is a one-cycle pulse on the same edge as the msb goes high
`timescale 1ns/1ps
`include "psi_cfg.svh"
module psi_sat_cnt
  import psi_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // control
  input wire logic inc,
  input wire logic clr,
  // results
  output logic [WIDTH-1:0] count,
  output logic half_evt
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;
  logic half_r;
  logic half_nxt;
  wire at_max = &cnt_r;
  wire [WIDTH-1:0] cnt_inc = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
  wire [WIDTH-1:0] cnt_one = {{(WIDTH-1){1'b0}}, 1'b1};

  // an increment in the clearing cycle is kept, so no event is lost
  assign cnt_nxt = clr ? (inc ? cnt_one : '0) :
                   (inc && !at_max) ? cnt_inc : cnt_r;
  // fires once, on the msb rising 0 to 1
  assign half_nxt = cnt_nxt[WIDTH-1] && !cnt_r[WIDTH-1];

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      half_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      half_r <= half_nxt;
    end
  end

  assign count = cnt_r;
  assign half_evt = half_r;

endmodule

// ==== hw/psi_top.sv ====
// Purpose: status summary, event latching and interrupt pin logic of a 10/100 transceiver
// Assumes: register port driven by the management frame engine on sys_clk
// Notes: link status inputs come from same-clock logic; only the shared pin is synchronised
//   pin sense resumes two edges after the pin stops driving
`timescale 1ns/1ps
`include "psi_cfg.svh"
module psi_top
  import psi_pkg::*;
#(
  parameter int CNT_WIDTH = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // management register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // line state from the transceiver core
  input wire logic link_up,
  input wire logic speed_10,
  input wire logic full_duplex,
  input wire logic jabber_seen,
  input wire logic loopback_on,
  input wire logic negotiation_done,
  input wire logic energy_present,
  input wire logic link_quality_evt,
  input wire logic false_carrier_evt,
  input wire logic rx_error_evt,
  // shared power-down / interrupt pin
  input wire logic powerdown_or_irq_pin_i,
  output logic powerdown_or_irq_pin_o,
  output logic powerdown_or_irq_pin_oe_n,
  // to power management
  output logic power_down_req
);

  // address match, used by read and write decode
  function automatic logic addr_is(input psi_addr_t a, input psi_addr_t ofs);
    addr_is = (a == ofs);
  endfunction

  // change detect, shared by the link, speed, duplex and energy events
  function automatic logic changed(input logic now_v, input logic was_v);
    changed = now_v ^ was_v;
  endfunction

  // control and status state
  logic [`PSI_CTL_WIDTH-1:0] ctl_r;
  logic [`PSI_CTL_WIDTH-1:0] ctl_nxt;
  psi_evt_t evt_en_r;
  psi_evt_t evt_en_nxt;
  psi_evt_t evt_st_r;
  psi_evt_t evt_st_nxt;
  psi_evt_t evt_now;

  // previous line state for change detection
  logic link_prev_r;
  logic speed_prev_r;
  logic duplex_prev_r;
  logic neg_prev_r;
  logic energy_prev_r;

  // read answer
  psi_word_t rdata_r;
  psi_word_t rdata_nxt;
  logic rvalid_r;

  // pin input synchroniser
  logic pin_meta_r;
  logic pin_sync_r;
  // recent output-select history; sense waits until our own level has left the flops
  logic [1:0] sel_hist_r;

  // interrupt output
  logic irq_r;
  logic irq_nxt;

  // counters
  psi_cnt_t fc_count;
  psi_cnt_t rxe_count;
  logic fc_half;
  logic rxe_half;

  // decode
  wire wr_ctl = reg_wr && addr_is(reg_addr, `PSI_OFS_CONTROL);
  wire wr_st = reg_wr && addr_is(reg_addr, `PSI_OFS_STATUS);
  wire rd_sum = reg_rd && addr_is(reg_addr, `PSI_OFS_SUMMARY);
  wire rd_ctl = reg_rd && addr_is(reg_addr, `PSI_OFS_CONTROL);
  wire rd_st = reg_rd && addr_is(reg_addr, `PSI_OFS_STATUS);
  wire rd_fc = reg_rd && addr_is(reg_addr, `PSI_OFS_FC_CNT);
  wire rd_rxe = reg_rd && addr_is(reg_addr, `PSI_OFS_RXE_CNT);

  // control fields
  wire out_sel = ctl_r[`PSI_CTL_OUT_SEL];
  wire global_en = ctl_r[`PSI_CTL_GLOBAL_EN];
  wire test_force = ctl_r[`PSI_CTL_TEST_FORCE];

  // counters live here so their half-full events feed the status bits
  psi_sat_cnt #(
    .WIDTH(CNT_WIDTH)
  ) u_fc_cnt (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .inc(false_carrier_evt),
    .clr(rd_fc),
    .count(fc_count),
    .half_evt(fc_half)
  );

  psi_sat_cnt #(
    .WIDTH(CNT_WIDTH)
  ) u_rxe_cnt (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .inc(rx_error_evt),
    .clr(rd_rxe),
    .count(rxe_count),
    .half_evt(rxe_half)
  );

  // events of this cycle, placed in status order
  always_comb
  begin
    evt_now = `PSI_RST_EVENTS;
    evt_now[`PSI_EV_LINK_QUAL] = link_quality_evt;
    evt_now[`PSI_EV_ENERGY] = changed(energy_present, energy_prev_r);
    evt_now[`PSI_EV_LINK] = changed(link_up, link_prev_r);
    evt_now[`PSI_EV_SPEED] = changed(speed_10, speed_prev_r);
    evt_now[`PSI_EV_DUPLEX] = changed(full_duplex, duplex_prev_r);
    evt_now[`PSI_EV_AN_DONE] = negotiation_done && !neg_prev_r;
    evt_now[`PSI_EV_FC_HALF] = fc_half;
    evt_now[`PSI_EV_RXE_HALF] = rxe_half;
  end

  // bits returned by a status read are dropped; events of the same cycle stay
  wire [7:0] st_read_clear = rd_st ? evt_st_r : `PSI_RST_EVENTS;
  // status latches regardless of enables; a new event beats the read clear
  assign evt_st_nxt = (evt_st_r & ~st_read_clear) | evt_now;

  // only the low byte of the status word is writable
  assign evt_en_nxt = wr_st ? reg_wdata[7:0] : evt_en_r;

  // upper control bits are dropped on write
  assign ctl_nxt = wr_ctl ? reg_wdata[`PSI_CTL_WIDTH-1:0] : ctl_r;

  // enabled pending events, gated by the global enable
  wire evt_pending = global_en && |(evt_st_r & evt_en_r);
  wire irq_pending = evt_pending || test_force;

  // next-state values keep the flop equal to the summary pending flag;
  // the read that clears status also drops the request on the same edge
  wire next_global_en = ctl_nxt[`PSI_CTL_GLOBAL_EN];
  wire next_evt_any = |(evt_st_nxt & evt_en_nxt);
  wire evt_after = next_global_en && next_evt_any;
  assign irq_nxt = evt_after || ctl_nxt[`PSI_CTL_TEST_FORCE];

  // summary word, no read side effects
  wire [15:0] summary_word = {
    8'h00,
    irq_pending,
    1'b0,
    jabber_seen && speed_10,
    negotiation_done,
    loopback_on,
    full_duplex,
    speed_10,
    link_up
  };

  wire [15:0] ctl_word = {13'h0000, ctl_r};
  wire [15:0] st_word = {evt_st_r, evt_en_r};
  wire [15:0] fc_word = {8'h00, fc_count};
  wire [15:0] rxe_word = {8'h00, rxe_count};

  // read mux, unmapped addresses answer zero
  assign rdata_nxt = rd_sum ? summary_word :
                     rd_ctl ? ctl_word :
                     rd_st ? st_word :
                     rd_fc ? fc_word :
                     rd_rxe ? rxe_word :
                     reg_rd ? `PSI_RST_WORD : rdata_r;

  // register file
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_r <= `PSI_RST_CONTROL;
      evt_en_r <= `PSI_RST_EVENTS;
      evt_st_r <= `PSI_RST_EVENTS;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      evt_en_r <= evt_en_nxt;
      evt_st_r <= evt_st_nxt;
    end
  end

  // line state history; reset to idle so a live link at release reports a change
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      link_prev_r <= 1'b0;
      speed_prev_r <= 1'b0;
      duplex_prev_r <= 1'b0;
      neg_prev_r <= 1'b0;
      energy_prev_r <= 1'b0;
    end
    else
    begin
      link_prev_r <= link_up;
      speed_prev_r <= speed_10;
      duplex_prev_r <= full_duplex;
      neg_prev_r <= negotiation_done;
      energy_prev_r <= energy_present;
    end
  end

  // read answer one edge after the strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_r <= `PSI_RST_WORD;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= reg_rd;
    end
  end

  // pin comes from off chip; two flops before use
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      sel_hist_r <= 2'b00;
    end
    else
    begin
      pin_meta_r <= powerdown_or_irq_pin_i;
      pin_sync_r <= pin_meta_r;
      sel_hist_r <= {sel_hist_r[0], out_sel};
    end
  end

  // interrupt request flop keeps the pin glitch free
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  // pin is active low when driven; input sense stops while it drives
  assign powerdown_or_irq_pin_oe_n = !out_sel;
  assign powerdown_or_irq_pin_o = !irq_r;
  // a low still held in the flops from our own interrupt must not read as a request;
  // costs two cycles of latency after the pin turns back into an input
  wire sense_armed = !out_sel && !sel_hist_r[0] && !sel_hist_r[1];
  assign power_down_req = sense_armed && !pin_sync_r;

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

endmodule

// ==== sim/psi_top_properties.sv ====
// Purpose: port assertions of psi_top
// Assumes: one clock, async active-low reset
// Notes: bound below
`timescale 1ns/1ps
module psi_chk
  import psi_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // line state
  input wire logic link_up,
  input wire logic speed_10,
  input wire logic full_duplex,
  input wire logic jabber_seen,
  input wire logic loopback_on,
  input wire logic negotiation_done,
  // pin
  input wire logic powerdown_or_irq_pin_i,
  input wire logic powerdown_or_irq_pin_o,
  input wire logic powerdown_or_irq_pin_oe_n,
  input wire logic power_down_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_sum_rd;
    reg_rd && reg_addr == 5'h10;
  endsequence
  sequence s_ctl_wr;
    reg_wr && reg_addr == 5'h11;
  endsequence
  a_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
    else $error("rvalid missing");
  a_ctl_upper_zero: assert property ((reg_rd && reg_addr == 5'h11) |=>
    reg_rdata[15:3] == 13'h0) else $error("ctl upper bits set");
  a_oe_follows_sel: assert property (s_ctl_wr |=>
    powerdown_or_irq_pin_oe_n == !$past(reg_wdata[0])) else $error("oe wrong");
  a_force_irq_low: assert property (s_ctl_wr ##0 reg_wdata[2] |->
    ##[1:2] !powerdown_or_irq_pin_o) else $error("force gave no irq");
  a_sum_link_bit: assert property (s_sum_rd |=> reg_rdata[0] == $past(link_up))
    else $error("link bit wrong");
  a_sum_jabber_bit: assert property (s_sum_rd |=>
    reg_rdata[5] == ($past(jabber_seen) && $past(speed_10))) else $error("jabber wrong");
  a_sum_mode_bits: assert property (s_sum_rd |=> reg_rdata[4:1] ==
    {$past(negotiation_done), $past(loopback_on), $past(full_duplex), $past(speed_10)})
    else $error("mode bits wrong");
  a_sum_pend_bit: assert property (s_sum_rd |=>
    reg_rdata[7] == !$past(powerdown_or_irq_pin_o)) else $error("pend bit wrong");
  a_pd_when_out: assert property (power_down_req == (powerdown_or_irq_pin_oe_n &&
    $past(powerdown_or_irq_pin_oe_n) && $past(powerdown_or_irq_pin_oe_n, 2) &&
    !$past(powerdown_or_irq_pin_i, 2))) else $error("pd request wrong");
endmodule
bind psi_top psi_chk u_chk (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .reg_rvalid, .link_up, .speed_10, .full_duplex, .jabber_seen, .loopback_on,
  .negotiation_done, .powerdown_or_irq_pin_i, .powerdown_or_irq_pin_o,
  .powerdown_or_irq_pin_oe_n, .power_down_req);

// ==== sim/psi_host_model.sv ====
// Purpose: management host issuing register strobes
// Assumes: one-cycle strobes, answer one edge later
// Notes: bounded wait, x on no answer
`timescale 1ns/1ps
module psi_host_model
  import psi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial
  begin
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input psi_addr_t a, input psi_word_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // caller trusts speed and duplex only with link up
  task rd(input psi_addr_t a, output psi_word_t d);
    d = 16'hXXXX;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      if (reg_rvalid === 1'b1)
      begin
        d = reg_rdata;
        break;
      end
    end
  endtask
endmodule

// ==== sim/tb_psi_top.sv ====
// Purpose: register-level test of psi_top
// Assumes: host model drives the register port
// Notes: pin level resolved from oe_n
`timescale 1ns/1ps
module tb_psi_top
  import psi_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, pin_o, pin_oe_n, power_down_req;
  logic link_up = 1'b0, speed_10 = 1'b0, full_duplex = 1'b0, jabber_seen = 1'b0;
  logic loopback_on = 1'b0, negotiation_done = 1'b0, energy_present = 1'b0;
  logic link_quality_evt = 1'b0, false_carrier_evt = 1'b0, rx_error_evt = 1'b0;
  logic pin_i = 1'b1;
  wire pin_w = pin_oe_n ? pin_i : pin_o;
  psi_word_t rd_v;
  int errors = 0;
  int comparisons = 0;
  always #5 sys_clk = ~sys_clk;
  psi_top #(.CNT_WIDTH(8)) uut (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .link_up, .speed_10, .full_duplex, .jabber_seen, .loopback_on,
    .negotiation_done, .energy_present, .link_quality_evt, .false_carrier_evt, .rx_error_evt,
    .powerdown_or_irq_pin_i(pin_w), .powerdown_or_irq_pin_o(pin_o),
    .powerdown_or_irq_pin_oe_n(pin_oe_n), .power_down_req);
  psi_host_model host (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd);
  task results;
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input psi_word_t seen, input psi_word_t exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task rc(input psi_addr_t a, input psi_word_t e, input string what);
    host.rd(a, rd_v);
    chk(rd_v, e, what);
  endtask
  task pulse(input int n, input bit rx);
    repeat (n)
    begin
      @(posedge sys_clk);
      false_carrier_evt <= !rx;
      rx_error_evt <= rx;
      @(posedge sys_clk);
      false_carrier_evt <= 1'b0;
      rx_error_evt <= 1'b0;
    end
  endtask
  // hang guard well above the run length
  initial
  begin
    #200000;
    errors++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    rc(5'h11, 16'h0000, "ctl rst");
    rc(5'h12, 16'h0000, "sts rst");
    chk(pin_oe_n, 16'h0001, "oe rst");
    host.wr(5'h11, 16'hFFFF);
    rc(5'h11, 16'h0007, "ctl wr");
    chk(pin_oe_n, 16'h0000, "oe on");
    chk(pin_o, 16'h0000, "force");
    host.wr(5'h11, 16'h0003);
    host.wr(5'h12, 16'hFFA5);
    rc(5'h12, 16'h00A5, "en");
    chk(pin_o, 16'h0001, "force off");
    host.wr(5'h12, 16'h0020);
    {link_up, speed_10, full_duplex, jabber_seen, loopback_on, negotiation_done} <= 6'h3F;
    repeat (3) @(posedge sys_clk);
    chk(pin_o, 16'h0000, "link irq");
    rc(5'h10, 16'h00BF, "sum");
    rc(5'h10, 16'h00BF, "sum again");
    rc(5'h12, 16'h3C20, "events");
    chk(pin_o, 16'h0001, "released");
    rc(5'h12, 16'h0020, "cleared");
    rc(5'h10, 16'h003F, "no pend");
    speed_10 <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(pin_o, 16'h0001, "masked");
    rc(5'h10, 16'h001D, "speed100");
    host.wr(5'h11, 16'h0001);
    host.wr(5'h12, 16'h00FF);
    energy_present <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(pin_o, 16'h0001, "global off");
    rc(5'h12, 16'h50FF, "gated ev");
    host.wr(5'h11, 16'h0003);
    pulse(127, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk(pin_o, 16'h0001, "fc 127");
    pulse(1, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk(pin_o, 16'h0000, "fc half");
    rc(5'h14, 16'h0080, "fc cnt");
    rc(5'h12, 16'h02FF, "fc ev");
    pulse(300, 1'b0);
    pulse(128, 1'b1);
    rc(5'h14, 16'h00FF, "fc sat");
    rc(5'h12, 16'h03FF, "both ev");
    rc(5'h15, 16'h0080, "rx cnt");
    link_quality_evt <= 1'b1;
    @(posedge sys_clk);
    link_quality_evt <= 1'b0;
    rc(5'h12, 16'h80FF, "quality");
    host.wr(5'h11, 16'h0005);
    repeat (3) @(posedge sys_clk);
    host.wr(5'h11, 16'h0000);
    @(posedge sys_clk);
    chk(power_down_req, 16'h0000, "pd held");
    pin_i <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(power_down_req, 16'h0001, "pd req");
    chk(pin_oe_n, 16'h0001, "pd in");
    results;
  end
endmodule
